// File: conv_cfg_pkg.sv
// Constants and types for the converter sync and channel configuration bank
package conv_cfg_pkg;
  localparam int SPI_ADDR_W = 15;
  localparam int SAMPLE_W = 14;
  localparam int RATIO_W = 6;
  localparam int NUM_DDC = 4;
  // Register addresses
  localparam logic [14:0] SYNC_BEHAVIOUR_SELECT_ADDR = 15'h01ff;
  localparam logic [14:0] CHANNEL_PATH_CONFIG_ADDR = 15'h0200;
  localparam logic [14:0] RATE_REDUCTION_SELECT_ADDR = 15'h0201;
  // Reset values
  localparam logic [7:0] SYNC_BEHAVIOUR_SELECT_RST = 8'h00;
  localparam logic [7:0] CHANNEL_PATH_CONFIG_RST = 8'h00;
  localparam logic [7:0] RATE_REDUCTION_SELECT_RST = 8'h00;
  // Field positions
  localparam int SYNC_MODE_BIT = 0;
  localparam int Q_IGNORE_BIT = 5;
  localparam int CHAN_RSVD_LSB = 6;
  localparam int APP_MODE_LSB = 0;
  localparam int DEC_CODE_LSB = 0;
  // Application mode codes
  localparam logic [3:0] APP_FULL_BW = 4'h0;
  localparam logic [3:0] APP_ONE_DDC = 4'h1;
  localparam logic [3:0] APP_TWO_DDC = 4'h2;
  localparam logic [3:0] APP_FOUR_DDC = 4'h3;
  // Decimation codes
  localparam logic [3:0] DEC_BY_1 = 4'h0;
  localparam logic [3:0] DEC_BY_2 = 4'h1;
  localparam logic [3:0] DEC_BY_3 = 4'h8;
  localparam logic [3:0] DEC_BY_4 = 4'h2;
  localparam logic [3:0] DEC_BY_5 = 4'h5;
  // Serial port framing
  localparam int RW_BIT = 15;
  localparam logic [4:0] INSTR_LAST = 5'h0f;
  localparam logic [4:0] DATA_LAST = 5'h07;

  typedef struct packed {
    logic sync_ts;
    logic [1:0] chan_rsvd;
    logic q_ignore;
    logic [3:0] app_mode;
    logic [3:0] dec_code;
  } cfg_s;

  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic ts;
  } out_word_s;

  typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA, SPI_DONE} spi_e;
endpackage

// File: conv_cfg_top.sv
// Serial-port register bank steering sync mode, channel paths and decimation
`timescale 1ns/1ps
module conv_cfg_top (
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_SDIO_IN,
  output logic SPI_SDIO_OUT,
  output logic SPI_SDIO_OE_OUT,
  input wire logic SYSREF_IN,
  input wire logic [conv_cfg_pkg::SAMPLE_W-1:0] SAMPLE_IN,
  output conv_cfg_pkg::out_word_s SAMPLE_WORD_OUT,
  output logic OUT_STROBE_OUT,
  output logic LINK_RESYNC_OUT,
  output logic [conv_cfg_pkg::NUM_DDC-1:0] DDC_ENABLE_OUT,
  output logic Q_PATH_EN_OUT,
  output logic DDC_BYPASS_OUT,
  output logic [conv_cfg_pkg::RATIO_W-1:0] DEC_RATIO_OUT
);
  import conv_cfg_pkg::*;

  function automatic logic [RATIO_W-1:0] dec_ratio(input logic [3:0] code);
    case (code)
      DEC_BY_2: dec_ratio = 6'h02;
      DEC_BY_3: dec_ratio = 6'h03;
      DEC_BY_4: dec_ratio = 6'h04;
      DEC_BY_5: dec_ratio = 6'h05;
      default: dec_ratio = 6'h01;
    endcase
  endfunction

  function automatic logic [NUM_DDC-1:0] ddc_enables(input logic [3:0] mode);
    case (mode)
      APP_ONE_DDC: ddc_enables = 4'h1;
      APP_TWO_DDC: ddc_enables = 4'h3;
      APP_FOUR_DDC: ddc_enables = 4'hf;
      default: ddc_enables = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] reg_read(input logic [14:0] addr,
                                          input cfg_s c);
    reg_read = 8'h00;
    case (addr)
      SYNC_BEHAVIOUR_SELECT_ADDR: reg_read[SYNC_MODE_BIT] = c.sync_ts;
      CHANNEL_PATH_CONFIG_ADDR: begin
        reg_read[CHAN_RSVD_LSB +: 2] = c.chan_rsvd;
        reg_read[Q_IGNORE_BIT] = c.q_ignore;
        reg_read[APP_MODE_LSB +: 4] = c.app_mode;
      end
      RATE_REDUCTION_SELECT_ADDR: reg_read[DEC_CODE_LSB +: 4] = c.dec_code;
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Pin synchronisers: stage 1 feeds stage 2 only
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic sclk_prev_q;
  logic sysref_prev_q;
  logic cs_n_s, sclk_s, sdio_s, sysref_s;
  assign {cs_n_s, sclk_s, sdio_s, sysref_s} = pin_sync_q;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      pin_meta_q <= 4'h8;
      pin_sync_q <= 4'h8;
      sclk_prev_q <= 1'b0;
      sysref_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {SPI_CS_N_IN, SPI_SCLK_IN, SPI_SDIO_IN, SYSREF_IN};
      pin_sync_q <= pin_meta_q;
      sclk_prev_q <= sclk_s;
      sysref_prev_q <= sysref_s;
    end
  end

  logic sclk_rise, sclk_fall, capture;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign capture = sysref_s & ~sysref_prev_q;

  // Serial port: 16-bit instruction then one data byte, MSB first
  spi_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [14:0] shift_q, shift_d;
  logic [14:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic [7:0] tx_q, tx_d;
  logic sdio_q, sdio_d;
  logic oe_q, oe_d;
  logic wr_en;
  logic [7:0] wr_data;
  cfg_s cfg_q, cfg_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    rd_d = rd_q;
    tx_d = tx_q;
    sdio_d = sdio_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    wr_data = {shift_q[6:0], sdio_s};
    if (cs_n_s) begin
      state_d = SPI_IDLE;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        SPI_IDLE: begin
          state_d = SPI_INSTR;
          cnt_d = 5'h00;
        end
        SPI_INSTR: if (sclk_rise) begin
          shift_d = {shift_q[13:0], sdio_s};
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == INSTR_LAST) begin
            rd_d = shift_q[RW_BIT-1];
            addr_d = {shift_q[13:0], sdio_s};
            tx_d = reg_read({shift_q[13:0], sdio_s}, cfg_q);
            cnt_d = 5'h00;
            state_d = SPI_DATA;
          end
        end
        SPI_DATA: begin
          if (sclk_fall && rd_q) begin
            sdio_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = 1'b1;
          end
          if (sclk_rise) begin
            shift_d = {shift_q[13:0], sdio_s};
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == DATA_LAST) begin
              wr_en = ~rd_q;
              state_d = SPI_DONE;
            end
          end
        end
        SPI_DONE: if (sclk_fall) oe_d = 1'b0;
        default: state_d = SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      state_q <= SPI_IDLE;
      cnt_q <= 5'h00;
      shift_q <= 15'h0000;
      addr_q <= 15'h0000;
      rd_q <= 1'b0;
      tx_q <= 8'h00;
      sdio_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      tx_q <= tx_d;
      sdio_q <= sdio_d;
      oe_q <= oe_d;
    end
  end

  // Register file
  always_comb begin
    cfg_d = cfg_q;
    if (wr_en) begin
      case (addr_q)
        SYNC_BEHAVIOUR_SELECT_ADDR: cfg_d.sync_ts = wr_data[SYNC_MODE_BIT];
        CHANNEL_PATH_CONFIG_ADDR: begin
          cfg_d.chan_rsvd = wr_data[CHAN_RSVD_LSB +: 2];
          cfg_d.q_ignore = wr_data[Q_IGNORE_BIT];
          cfg_d.app_mode = wr_data[APP_MODE_LSB +: 4];
        end
        RATE_REDUCTION_SELECT_ADDR: cfg_d.dec_code = wr_data[DEC_CODE_LSB +: 4];
        default: cfg_d = cfg_q;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      cfg_q.sync_ts <= SYNC_BEHAVIOUR_SELECT_RST[SYNC_MODE_BIT];
      cfg_q.chan_rsvd <= CHANNEL_PATH_CONFIG_RST[CHAN_RSVD_LSB +: 2];
      cfg_q.q_ignore <= CHANNEL_PATH_CONFIG_RST[Q_IGNORE_BIT];
      cfg_q.app_mode <= CHANNEL_PATH_CONFIG_RST[APP_MODE_LSB +: 4];
      cfg_q.dec_code <= RATE_REDUCTION_SELECT_RST[DEC_CODE_LSB +: 4];
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Divider chain, timestamping and datapath controls
  logic [RATIO_W-1:0] div_q, div_d, ratio_d, ratio_q;
  logic link_drop_q, link_drop_d;
  out_word_s word_q, word_d;
  logic strobe_q, strobe_d;
  logic [NUM_DDC-1:0] ddc_en_q, ddc_en_d;
  logic q_en_q, q_en_d, bypass_q, bypass_d;

  always_comb begin
    ratio_d = dec_ratio(cfg_q.dec_code);
    bypass_d = (cfg_q.dec_code == DEC_BY_1);
    ddc_en_d = ddc_enables(cfg_q.app_mode);
    q_en_d = ~cfg_q.q_ignore;
    div_d = (div_q >= ratio_q - 6'h01) ? 6'h00 : div_q + 6'h01;
    link_drop_d = 1'b0;
    word_d.data = SAMPLE_IN;
    word_d.ts = 1'b0;
    if (capture) begin
      if (!cfg_q.sync_ts) begin
        // Drop only if the free-running phase would not land on 0 anyway
        link_drop_d = (div_d != 6'h00);
        div_d = 6'h00;
      end else begin
        word_d.ts = 1'b1;
      end
    end
    strobe_d = (div_d == 6'h00);
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      div_q <= 6'h00;
      ratio_q <= 6'h01;
      link_drop_q <= 1'b0;
      word_q <= '0;
      strobe_q <= 1'b0;
      ddc_en_q <= 4'h0;
      q_en_q <= 1'b1;
      bypass_q <= 1'b1;
    end else begin
      div_q <= div_d;
      ratio_q <= ratio_d;
      link_drop_q <= link_drop_d;
      word_q <= word_d;
      strobe_q <= strobe_d;
      ddc_en_q <= ddc_en_d;
      q_en_q <= q_en_d;
      bypass_q <= bypass_d;
    end
  end

  assign SPI_SDIO_OUT = sdio_q;
  assign SPI_SDIO_OE_OUT = oe_q;
  assign SAMPLE_WORD_OUT = word_q;
  assign OUT_STROBE_OUT = strobe_q;
  assign LINK_RESYNC_OUT = link_drop_q;
  assign DDC_ENABLE_OUT = ddc_en_q;
  assign Q_PATH_EN_OUT = q_en_q;
  assign DDC_BYPASS_OUT = bypass_q;
  assign DEC_RATIO_OUT = ratio_q;
endmodule // conv_cfg_top

// File: conv_cfg_checker.sv
// Assertions on the sync, link and configuration outputs of the bank
`timescale 1ns/1ps
module conv_cfg_checker
  import conv_cfg_pkg::*;
(
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic SYSREF_IN,
  input wire logic [SAMPLE_W-1:0] SAMPLE_IN,
  input out_word_s SAMPLE_WORD_OUT,
  input wire logic LINK_RESYNC_OUT,
  input wire logic [NUM_DDC-1:0] DDC_ENABLE_OUT,
  input wire logic DDC_BYPASS_OUT,
  input wire logic [RATIO_W-1:0] DEC_RATIO_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  logic sref_q;
  logic [3:0] age_q, age_d;
  // Cycles since the reference pin last rose
  always_comb begin
    age_d = age_q;
    if (SYSREF_IN && !sref_q) age_d = 4'h1;
    else if (age_q != 4'hf) age_d = age_q + 4'h1;
    if (!RESET_N_IN) age_d = 4'hf;
  end
  always_ff @(posedge REF_CLK_IN) begin
    sref_q <= SYSREF_IN;
    age_q <= age_d;
  end
  resync_cause_a: assert property (LINK_RESYNC_OUT |-> age_q inside {[3:7]})
    else $error("link drop without reference pulse");
  resync_pulse_a: assert property (LINK_RESYNC_OUT |=> !LINK_RESYNC_OUT)
    else $error("link drop longer than one cycle");
  ts_cause_a: assert property (SAMPLE_WORD_OUT.ts |-> age_q inside {[3:7]})
    else $error("sample mark without reference pulse");
  ts_pulse_a: assert property (SAMPLE_WORD_OUT.ts |=> !SAMPLE_WORD_OUT.ts)
    else $error("sample mark longer than one cycle");
  mode_excl_a: assert property (SAMPLE_WORD_OUT.ts |-> (!LINK_RESYNC_OUT) [*3])
    else $error("link dropped in timestamp mode");
  data_delay_a: assert property ($past(RESET_N_IN) |->
    SAMPLE_WORD_OUT.data == $past(SAMPLE_IN))
    else $error("sample word data not one cycle late");
  bypass_unit_a: assert property (DDC_BYPASS_OUT |-> DEC_RATIO_OUT == 6'h01)
    else $error("bypass with ratio other than one");
  ratio_set_a: assert property (DEC_RATIO_OUT inside {[6'h01:6'h05]})
    else $error("decimation ratio out of set");
  ddc_mask_a: assert property (DDC_ENABLE_OUT inside {4'h0, 4'h1, 4'h3, 4'hf})
    else $error("illegal channel mask");
  cover property (SAMPLE_WORD_OUT.ts);
  cover property (LINK_RESYNC_OUT);
  cover property (DDC_ENABLE_OUT == 4'hf);
endmodule // conv_cfg_checker

bind conv_cfg_top conv_cfg_checker i_conv_cfg_checker (
  .REF_CLK_IN(REF_CLK_IN),
  .RESET_N_IN(RESET_N_IN),
  .SYSREF_IN(SYSREF_IN),
  .SAMPLE_IN(SAMPLE_IN),
  .SAMPLE_WORD_OUT(SAMPLE_WORD_OUT),
  .LINK_RESYNC_OUT(LINK_RESYNC_OUT),
  .DDC_ENABLE_OUT(DDC_ENABLE_OUT),
  .DDC_BYPASS_OUT(DDC_BYPASS_OUT),
  .DEC_RATIO_OUT(DEC_RATIO_OUT)
);

// File: conv_cfg_top_tb.sv
// Self-checking bench for the sync and channel configuration bank
`timescale 1ns/1ps
module conv_cfg_top_tb;
  import conv_cfg_pkg::*;
  typedef struct packed {
    logic [14:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic [11:0] o;
  } row_s;
  logic clk = 0, rst_n = 0, cs_n = 1, sclk = 0, sdi = 0, sref = 0;
  logic [SAMPLE_W-1:0] samp = '0;
  logic sdo, oe, strobe, rs, q, byp;
  logic [3:0] ddc;
  logic [RATIO_W-1:0] ratio;
  logic [7:0] rd;
  logic [11:0] ov;
  out_word_s word;
  int err_total = 0, checks_done = 0, n_ts, n_rs, n_st;
  row_s rows [12] = '{'{15'h200, 8'h01, 8'h01, 12'h1c1},
    '{15'h200, 8'h22, 8'h22, 12'h341}, '{15'h200, 8'hd3, 8'hc3, 12'hfc1},
    '{15'h201, 8'h01, 8'h01, 12'hf82}, '{15'h201, 8'hf8, 8'h08, 12'hf83},
    '{15'h201, 8'h02, 8'h02, 12'hf84}, '{15'h201, 8'h05, 8'h05, 12'hf85},
    '{15'h201, 8'h00, 8'h00, 12'hfc1}, '{15'h1ff, 8'hff, 8'h01, 12'hfc1},
    '{15'h1ff, 8'h00, 8'h00, 12'hfc1}, '{15'h202, 8'h55, 8'h00, 12'hfc1},
    '{15'h200, 8'h07, 8'h07, 12'h0c1}};
  assign ov = {ddc, q, byp, ratio};
  conv_cfg_top i_conv_cfg_top (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
    .SPI_CS_N_IN(cs_n), .SPI_SCLK_IN(sclk), .SPI_SDIO_IN(sdi),
    .SPI_SDIO_OUT(sdo), .SPI_SDIO_OE_OUT(oe), .SYSREF_IN(sref),
    .SAMPLE_IN(samp), .SAMPLE_WORD_OUT(word), .OUT_STROBE_OUT(strobe),
    .LINK_RESYNC_OUT(rs), .DDC_ENABLE_OUT(ddc), .Q_PATH_EN_OUT(q),
    .DDC_BYPASS_OUT(byp), .DEC_RATIO_OUT(ratio));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) samp <= samp + 1'b1;
  // Pulse counters, sampled away from the launching edge
  always @(negedge clk) begin
    if (word.ts === 1'b1) n_ts++;
    if (rs === 1'b1) n_rs++;
    if (strobe === 1'b1) n_st++;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [14:0] g, input logic [14:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task xfer(input logic [23:0] f);
    @(posedge clk) cs_n <= 1'b0;
    tick(6);
    for (int i = 23; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi <= f[i];
      tick(6);
      @(negedge clk);
      if (i < 8) begin
        rd[i] = sdo;
        chk(15'(oe), 15'(f[23]));
      end
      @(posedge clk) sclk <= 1'b1;
      tick(5);
    end
    cs_n <= 1'b1;
    tick(6);
  endtask
  task pulse;
    sref <= 1'b1;
    tick(2);
    sref <= 1'b0;
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    chk(15'(ov), 15'h0c1);
    @(negedge clk);
    chk(15'(word), 15'({samp - 14'h1, 1'b0}));
    chk(15'({oe, rs}), 15'h0);
    for (int k = 0; k < 3; k++) begin
      xfer({1'b1, 15'h1ff + 15'(k), 8'h00});
      chk(15'(rd), 15'h0);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      xfer({1'b0, rows[i].a, rows[i].w});
      xfer({1'b1, rows[i].a, 8'h00});
      chk(15'(rd), 15'(rows[i].r));
      chk(15'(ov), 15'(rows[i].o));
    end
    $display("table test done");
    xfer({1'b0, 15'h201, 8'h02});
    for (int n = 8; n < 10; n++) begin
      pulse;
      tick(n - 2);
      n_rs = 0;
      pulse;
      tick(12);
      chk(15'(n_rs), 15'(n - 8));
    end
    $display("divider reset test done");
    xfer({1'b0, 15'h1ff, 8'h01});
    n_ts = 0;
    n_rs = 0;
    n_st = 0;
    pulse;
    tick(38);
    chk(15'(n_st), 15'd10);
    chk(15'(n_rs), 15'd0);
    chk(15'(n_ts), 15'd1);
    $display("timestamp test done");
    close_out;
  end
endmodule // conv_cfg_top_tb
